// >>> dv/master_stub.sv
// Purpose: Upstream chained modulator stand-in for the slave scenario
// Assumes: Same clock as the block under test
// Notes:   Emits one-cycle sync and load pulses on request only
`default_nettype none
module master_stub (
  input  wire logic clk,    // Shared clock
  input  wire logic rst_b,  // Reset, active low
  input  wire logic go,     // One-cycle restart request
  output var  logic sync_o, // Period sync pulse
  output var  logic load_o  // Shadow load pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_o <= 1'b0;
      load_o <= 1'b0;
    end else begin
      sync_o <= go;
      load_o <= go;
    end
  end
endmodule // master_stub
`default_nettype wire

// >>> dv/pwm_props.sv
// Purpose: Port-level checks of the six channel modulator
// Assumes: Byte map of pwm_defs.vh, zero-wait bus
// Notes:   Copies of bus writes tell the checks which mode is set
`include "pwm_defs.vh"
`default_nettype none
module pwm_props #(
  parameter NCH = 6
) (
  input wire logic           clk,              // Clock
  input wire logic           rst_b,            // Reset, active low
  input wire logic           psel,             // Bus select
  input wire logic           penable,          // Bus access phase
  input wire logic           pwrite,           // Bus write
  input wire logic [7:0]     paddr,            // Bus address
  input wire logic [31:0]    pwdata,           // Bus write data
  input wire logic           pready,           // Bus ready
  input wire logic           pslverr,          // Bus error
  input wire logic           hold_pin,         // Fault input
  input wire logic           carrier_pin,      // Burst carrier
  input wire logic [NCH-1:0] match_output_pin, // Outputs
  input wire logic           period_sync_out,  // Sync to slave
  input wire logic           shadow_load_out,  // Load to slave
  input wire logic           irq               // Interrupt
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------
  // Mode copies
  // ----------------------------------------------------------------
  logic [7:0]     ctrl_r;
  logic [NCH-1:0] lvl_r;
  logic [16:0]    mask_r;
  logic           wr_now;
  assign wr_now = psel && penable && pwrite && pready;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= 8'h00;
      lvl_r  <= '0;
      mask_r <= 17'h0;
    end else if (wr_now) begin
      if (paddr == `OFS_CTRL)
        ctrl_r <= pwdata[7:0];
      if (paddr == `OFS_HOLD_LVL)
        lvl_r <= pwdata[NCH-1:0];
      if (paddr == `OFS_INT_MASK)
        mask_r <= pwdata[16:0];
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_sync_narrow: assert property (
    period_sync_out |=> !period_sync_out)
    else $error("sync pulse wider than one cycle");
  a_load_with_sync: assert property (
    shadow_load_out |-> period_sync_out)
    else $error("load pulse without sync pulse");
  a_zero_wait: assert property (psel && penable |-> pready)
    else $error("bus access not answered at once");
  a_err_phase: assert property (pslverr |-> psel && penable)
    else $error("bus error outside access phase");
  a_err_unmapped: assert property (
    psel && penable && paddr == 8'h30 |-> pslverr)
    else $error("unmapped access without error");
  a_irq_masked: assert property ((mask_r == 17'h0) [*3] |-> !irq)
    else $error("interrupt with all sources masked");
  a_hold_level: assert property (
    ctrl_r[2] && $rose(hold_pin) |->
    ##[1:12] match_output_pin == lvl_r)
    else $error("hold levels not applied");
  a_burst_gate: assert property (
    (ctrl_r[3] && !ctrl_r[2] && !carrier_pin) [*8] |->
    ##3 match_output_pin == '0)
    else $error("output active with carrier low");
  c_sync_load: cover property (period_sync_out && shadow_load_out);
  c_hold: cover property (ctrl_r[2] && $rose(hold_pin));
  c_irq: cover property ($rose(irq));
endmodule // pwm_props
bind six_channel_pwm pwm_props #(.NCH(NCH)) i_pwm_props (
  .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .hold_pin(hold_pin), .carrier_pin(carrier_pin),
  .match_output_pin(match_output_pin), .period_sync_out(period_sync_out),
  .shadow_load_out(shadow_load_out), .irq(irq)
);
`default_nettype wire

// >>> dv/tb_top.sv
// Purpose: Self-checking bench of the six channel modulator
// Assumes: 10 MHz clock, zero-wait bus, stub on the sync inputs
// Notes:   Prescale 1 and period 9 give twenty clocks a period
`include "pwm_defs.vh"
`default_nettype none
`define CHK(n, e, v) begin \
  num_checks++; \
  if ((v) !== (e)) begin \
    bad_count++; \
    $display("wrong value %s expected %h seen %h", n, e, v); \
  end \
end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [2:0]  capture_pin = 3'h0;
  logic        hold_pin = 1'b0;
  logic        carrier_pin = 1'b0;
  logic        go = 1'b0;
  logic [31:0] prdata, q;
  logic [5:0]  match_output_pin;
  logic        pready, pslverr, irq, e;
  logic        period_sync_in, shadow_load_in;
  logic        period_sync_out, shadow_load_out;
  int          bad_count = 0;
  int          num_checks = 0;
  int          n;
  always #50 clk = ~clk;
  six_channel_pwm i_six_channel_pwm (.clk(clk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_pin(capture_pin), .hold_pin(hold_pin),
    .carrier_pin(carrier_pin), .match_output_pin(match_output_pin),
    .period_sync_in(period_sync_in), .shadow_load_in(shadow_load_in),
    .period_sync_out(period_sync_out), .shadow_load_out(shadow_load_out),
    .irq(irq));
  master_stub i_master_stub (.clk(clk), .rst_b(rst_b), .go(go),
    .sync_o(period_sync_in), .load_o(shadow_load_in));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Bounded waits: a stuck output falls through to a failing compare
  task automatic hi_width(output int w);
    repeat (60) if (match_output_pin[0] !== 1'b0) @(posedge clk);
    repeat (60) if (match_output_pin[0] !== 1'b1) @(posedge clk);
    w = 0;
    do begin
      @(posedge clk);
      w++;
    end while (match_output_pin[0] === 1'b1 && w < 60);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    apb(0, `OFS_PRESC, 0);
    `CHK("presc reset", 32'h0, q)
    apb(0, `OFS_PERIOD, 0);
    `CHK("period reset", 32'hffff, q)
    apb(0, 8'h30, 0);
    `CHK("unmapped error", 1'b1, e)
    apb(1, `OFS_COUNT, 32'h5);
    apb(0, `OFS_COUNT, 0);
    `CHK("count idle", 32'h0, q)
  endtask
  task automatic t_wave;
    apb(1, `OFS_PRESC, 32'h1);
    apb(1, `OFS_PERIOD, 32'h9);
    apb(1, 8'h40, 32'h2);
    apb(1, 8'h44, 32'h5);
    apb(1, `OFS_CTRL, 32'h20);
    apb(1, `OFS_CTRL, 32'h21);
    hi_width(n);
    `CHK("high width", 6, n)
    repeat (60) if (period_sync_out !== 1'b1) @(posedge clk);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (period_sync_out !== 1'b1 && n < 60);
    `CHK("sync spacing", 20, n)
    `CHK("no load pulse", 1'b0, shadow_load_out)
    apb(1, 8'h40, 32'h4);
    hi_width(n);
    `CHK("width before load", 6, n)
    apb(1, `OFS_CTRL, 32'h21);
    repeat (60) if (shadow_load_out !== 1'b1) @(posedge clk);
    `CHK("load pulse", 1'b1, shadow_load_out)
    hi_width(n);
    `CHK("width after load", 2, n)
  endtask
  task automatic t_irq;
    apb(1, `OFS_INT_MASK, 32'h1);
    repeat (60) if (irq !== 1'b1) @(posedge clk);
    `CHK("irq raised", 1'b1, irq)
    apb(0, `OFS_INT_STAT, 0);
    `CHK("rise status", 1'b1, q[0])
    `CHK("wrap status", 1'b1, q[15])
    apb(1, `OFS_INT_MASK, 32'h0);
    repeat (3) @(posedge clk);
    `CHK("irq masked", 1'b0, irq)
  endtask
  task automatic t_once;
    apb(1, `OFS_CTRL, 32'h0);
    apb(1, `OFS_CTRL, 32'h3);
    apb(0, `OFS_CTRL, 0);
    `CHK("once running", 1'b1, q[7])
    repeat (40) @(posedge clk);
    apb(0, `OFS_CTRL, 0);
    `CHK("once stopped", 1'b0, q[7])
    apb(0, `OFS_COUNT, 0);
    `CHK("once count", 32'h0, q)
  endtask
  task automatic t_cap;
    apb(1, `OFS_CTRL, 32'h1);
    capture_pin <= 3'h1;
    repeat (4) @(posedge clk);
    capture_pin <= 3'h0;
    repeat (8) @(posedge clk);
    apb(0, `OFS_INT_STAT, 0);
    `CHK("capture flags", 3'h1, q[14:12])
    apb(0, `OFS_CAP0, 0);
    `CHK("capture range", 1'b1, q[15:0] <= 16'h9)
  endtask
  task automatic t_hold;
    apb(1, `OFS_HOLD_LVL, 32'h2a);
    apb(1, `OFS_CTRL, 32'h5);
    hold_pin <= 1'b1;
    repeat (12) @(posedge clk);
    `CHK("hold levels", 6'h2a, match_output_pin)
    apb(0, `OFS_INT_STAT, 0);
    `CHK("hold status", 1'b1, q[16])
    apb(1, `OFS_CTRL, 32'h40);
    hold_pin <= 1'b0;
  endtask
  task automatic t_burst;
    apb(1, `OFS_CTRL, 32'h9);
    repeat (20) @(posedge clk);
    `CHK("burst gated", 6'h0, match_output_pin)
    carrier_pin <= 1'b1;
    // Let the carrier filter settle so no clipped pulse is measured
    repeat (6) @(posedge clk);
    hi_width(n);
    `CHK("burst width", 2, n)
  endtask
  // Start at edge A, pulse three cycles after A+1, seen one edge later
  task automatic t_delay;
    apb(1, `OFS_SYNC_DLY, 32'h3);
    apb(1, `OFS_CTRL, 32'h0);
    apb(1, `OFS_CTRL, 32'h21);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (period_sync_out !== 1'b1 && n < 60);
    `CHK("sync delay", 5, n)
    `CHK("delayed load", 1'b1, shadow_load_out)
    apb(1, `OFS_SYNC_DLY, 32'h0);
  endtask
  task automatic t_slave;
    apb(1, `OFS_CTRL, 32'h0);
    apb(1, `OFS_CTRL, 32'h11);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (11) @(posedge clk);
    apb(0, `OFS_COUNT, 0);
    `CHK("slave running", 16'h5, q[15:0])
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    apb(0, `OFS_COUNT, 0);
    `CHK("slave restart", 1'b1, q[15:0] <= 16'h2)
  endtask
  // ----------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs;
    t_wave;
    t_irq;
    t_once;
    t_cap;
    t_hold;
    t_burst;
    t_delay;
    t_slave;
    report_and_stop;
  end
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire

// >>> hdl/pwm_defs.vh
// Purpose: Register map and reset values of the six channel modulator
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef PWM_DEFS_VH
`define PWM_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_CTRL      8'h00
`define OFS_PRESC     8'h04
`define OFS_PERIOD    8'h08
`define OFS_SYNC_DLY  8'h0c
`define OFS_HOLD_LVL  8'h10
`define OFS_COUNT     8'h14
`define OFS_INT_STAT  8'h18
`define OFS_INT_MASK  8'h1c
`define OFS_CAP0      8'h20
`define OFS_CAP1      8'h24
`define OFS_CAP2      8'h28
`define OFS_EDGE_BASE 2'b01

// ----------------------------------------------------------------
// Control bits
// ----------------------------------------------------------------
`define CTRL_RUN      0
`define CTRL_ONCE     1
`define CTRL_HOLD_EN  2
`define CTRL_BURST    3
`define CTRL_SLAVE    4
`define CTRL_LOAD     5
`define CTRL_HOLD_CLR 6
`define CTRL_ACTIVE   7

// ----------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------
`define ST_RISE       0
`define ST_FALL       6
`define ST_CAP        12
`define ST_OVF        15
`define ST_HOLD       16
`define ST_W          17

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_PRESC     16'h0000
`define RST_PERIOD    16'hffff
`define RST_EDGE      16'h0000
`define RST_DLY       16'h0000

`endif

// >>> hdl/six_channel_pwm.v
// Purpose: Six output double edge modulator with hold, capture, burst
//          and master/slave period alignment
// Assumes: One clock; chained neighbours run on the same clock
// Notes:   Software values reach the counters via shadow copies
//
// Operation
// - Six independent match outputs, all timed by one period counter.
// - Each output has its own rising and falling edge position.
// - Each rise or fall match can raise an individually masked interrupt.
// - Continuous mode repeats periods; run-once stops after one period.
// - Sixteen-bit prescaler divides clock and steps sixteen-bit counter.
// - Fault event holds outputs at software levels, optional interrupt.
// - Three capture pins latch the counter, optional interrupt.
// - Interrupts from match, capture, overflow and fault hold.
// - Burst mode gates the modulated waveform with an external carrier.
// - Master emits a one-cycle period sync pulse at each restart.
// - Shadow-load pulse accompanies sync only when shadows were loaded.
// - Programmable delay before the sync and shadow-load pulses.
// - Slave restarts on incoming sync, loads shadows on incoming load.
// - Chaining runs one way, module n master over module n plus one.
// - Prescaler and sync delay count module clock periods; period counter and edge values count prescaler steps.
// - Counters use shadow copies; bus side holds the system registers.
//
// Design decisions made here: the register offsets and the APB slave port.
`include "pwm_defs.vh"
`default_nettype none

module six_channel_pwm #(
  parameter NCH = 6,
  parameter CW  = 16
) (
  input  wire            clk,              // Module clock
  input  wire            rst_b,            // Async reset, active low
  input  wire            psel,             // APB select
  input  wire            penable,          // APB access phase
  input  wire            pwrite,           // APB write
  input  wire [7:0]      paddr,            // APB byte address
  input  wire [31:0]     pwdata,           // APB write data
  output reg  [31:0]     prdata,           // APB read data
  output wire            pready,           // APB ready
  output wire            pslverr,          // APB error
  input  wire [2:0]      capture_pin,      // Capture inputs
  input  wire            hold_pin,         // Fault input
  input  wire            carrier_pin,      // Burst carrier input
  output reg  [NCH-1:0]  match_output_pin, // Modulated outputs
  input  wire            period_sync_in,   // Sync from master
  input  wire            shadow_load_in,   // Load from master
  output reg             period_sync_out,  // Sync to slave
  output reg             shadow_load_out,  // Load to slave
  output reg             irq               // Interrupt level
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  reg rst_q1_r;
  reg rst_b_r;
  wire rst_n;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_q1_r <= 1'b0;
      rst_b_r  <= 1'b0;
    end else begin
      rst_q1_r <= 1'b1;
      rst_b_r  <= rst_q1_r;
    end
  end

  assign rst_n = rst_b_r;

  // ----------------------------------------------------------------
  // Pin synchronisers and agreement filter
  // ----------------------------------------------------------------
  // Bits: 2:0 capture, 3 fault, 4 carrier
  wire [4:0] pins;
  reg  [4:0] s1_r;
  reg  [4:0] s2_r;
  reg  [4:0] s3_r;
  reg  [4:0] flt_r;
  reg  [4:0] flt_d_r;
  wire [4:0] flt_nxt;
  wire [4:0] rise_ev;

  assign pins    = {carrier_pin, hold_pin, capture_pin};
  // Level changes only once the last two stages agree
  assign flt_nxt = (s2_r & s3_r) | (flt_r & (s2_r ^ s3_r));
  assign rise_ev = flt_r & ~flt_d_r;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r    <= 5'h00;
      s2_r    <= 5'h00;
      s3_r    <= 5'h00;
      flt_r   <= 5'h00;
      flt_d_r <= 5'h00;
    end else begin
      s1_r    <= pins;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      flt_r   <= flt_nxt;
      flt_d_r <= flt_r;
    end
  end

  // ----------------------------------------------------------------
  // System registers
  // ----------------------------------------------------------------
  reg  [7:0]      ctrl_r;
  reg  [CW-1:0]   presc_r;
  reg  [CW-1:0]   period_r;
  reg  [CW-1:0]   dly_r;
  reg  [NCH-1:0]  lvl_r;
  reg  [`ST_W-1:0] stat_r;
  reg  [`ST_W-1:0] mask_r;
  reg  [CW-1:0]   cap_r [0:2];
  reg  [CW-1:0]   rise_r [0:NCH-1];
  reg  [CW-1:0]   fall_r [0:NCH-1];
  reg             hold_act_r;
  reg             err_r;

  // Shadow copies used by the counters
  reg  [CW-1:0]   presc_s;
  reg  [CW-1:0]   period_s;
  reg  [CW-1:0]   rise_s [0:NCH-1];
  reg  [CW-1:0]   fall_s [0:NCH-1];

  wire acc    = psel & penable;
  wire acc_wr = acc & pwrite;
  wire acc_rd = acc & ~pwrite;
  wire edge_hit = (paddr[7:6] == `OFS_EDGE_BASE) &&
                  (paddr[5:3] < NCH) && (paddr[1:0] == 2'b00);
  wire [2:0] eidx = paddr[5:3];

  assign pready  = 1'b1;
  assign pslverr = acc & err_r;

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  reg  [CW-1:0]  pre_r;
  reg  [CW-1:0]  cnt_r;
  reg            run_d_r;
  reg  [CW-1:0]  dcnt_r;
  reg            dpend_r;
  reg            dload_r;

  wire run    = ctrl_r[`CTRL_RUN];
  wire once   = ctrl_r[`CTRL_ONCE];
  wire slave  = ctrl_r[`CTRL_SLAVE];
  wire tick   = run && (pre_r == presc_s);
  wire wrap   = tick && (cnt_r == period_s);
  wire start  = slave ? (run & period_sync_in)
                      : (run & ~run_d_r);
  wire restart  = start | (wrap & ~once);
  wire stop     = wrap & once;
  wire do_load  = slave ? shadow_load_in
                        : (restart & ctrl_r[`CTRL_LOAD]);

  // Match detection on the first prescaler step of each count
  reg [NCH-1:0] mrise;
  reg [NCH-1:0] mfall;
  integer k;

  always @* begin
    mrise = {NCH{1'b0}};
    mfall = {NCH{1'b0}};
    for (k = 0; k < NCH; k = k + 1) begin
      // Start cycle skipped: shadows load on that edge
      mrise[k] = run && !start && (pre_r == {CW{1'b0}}) &&
                 (cnt_r == rise_s[k]);
      mfall[k] = run && !start && (pre_r == {CW{1'b0}}) &&
                 (cnt_r == fall_s[k]);
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_r   <= {CW{1'b0}};
      cnt_r   <= {CW{1'b0}};
      run_d_r <= 1'b0;
    end else begin
      run_d_r <= run;
      if (restart || !run) begin
        pre_r <= {CW{1'b0}};
        cnt_r <= {CW{1'b0}};
      end else if (tick) begin
        pre_r <= {CW{1'b0}};
        if (!wrap)
          cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
      end else begin
        pre_r <= pre_r + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

  // ----------------------------------------------------------------
  // Shadow transfer
  // ----------------------------------------------------------------
  // Master copies only at restart, slave on shadow_load_in, so a period is never torn
  integer j;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_s  <= `RST_PRESC;
      period_s <= `RST_PERIOD;
      for (j = 0; j < NCH; j = j + 1) begin
        rise_s[j] <= `RST_EDGE;
        fall_s[j] <= `RST_EDGE;
      end
    end else if (do_load) begin
      presc_s  <= presc_r;
      period_s <= period_r;
      for (j = 0; j < NCH; j = j + 1) begin
        rise_s[j] <= rise_r[j];
        fall_s[j] <= fall_r[j];
      end
    end
  end

  // ----------------------------------------------------------------
  // Sync and shadow-load pulses with delay
  // ----------------------------------------------------------------
  // A fresh restart during a pending delay replaces the old one
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dcnt_r          <= {CW{1'b0}};
      dpend_r         <= 1'b0;
      dload_r         <= 1'b0;
      period_sync_out <= 1'b0;
      shadow_load_out <= 1'b0;
    end else begin
      period_sync_out <= 1'b0;
      shadow_load_out <= 1'b0;
      if (restart) begin
        if (dly_r == {CW{1'b0}}) begin
          period_sync_out <= 1'b1;
          shadow_load_out <= do_load;
          dpend_r         <= 1'b0;
        end else begin
          dcnt_r  <= dly_r;
          dload_r <= do_load;
          dpend_r <= 1'b1;
        end
      end else if (dpend_r) begin
        if (dcnt_r == {{(CW-1){1'b0}}, 1'b1}) begin
          period_sync_out <= 1'b1;
          shadow_load_out <= dload_r;
          dpend_r         <= 1'b0;
        end
        dcnt_r <= dcnt_r - {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  reg [NCH-1:0] wave_r;
  integer m;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wave_r <= {NCH{1'b0}};
    end else begin
      for (m = 0; m < NCH; m = m + 1) begin
        if (mrise[m])
          wave_r[m] <= 1'b1;
        else if (mfall[m])
          wave_r[m] <= 1'b0;
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      match_output_pin <= {NCH{1'b0}};
    end else if (hold_act_r) begin
      match_output_pin <= lvl_r;
    end else if (ctrl_r[`CTRL_BURST]) begin
      match_output_pin <= wave_r & {NCH{flt_r[4]}};
    end else begin
      match_output_pin <= wave_r;
    end
  end

  // ----------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------
  wire hold_ev = rise_ev[3] & ctrl_r[`CTRL_HOLD_EN];
  wire [`ST_W-1:0] ev = {hold_ev, wrap, rise_ev[2:0],
                         mfall, mrise};
  wire stat_clr = acc_rd && (paddr == `OFS_INT_STAT);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_r     <= {`ST_W{1'b0}};
      irq        <= 1'b0;
      hold_act_r <= 1'b0;
    end else begin
      // Only bits reported at setup clear, so no event is lost
      stat_r <= (stat_clr ? (stat_r & ~prdata[`ST_W-1:0]) : stat_r) |
                ev;
      irq    <= |(stat_r & mask_r);
      if (hold_ev)
        hold_act_r <= 1'b1;
      else if (acc_wr && (paddr == `OFS_CTRL) &&
               pwdata[`CTRL_HOLD_CLR])
        hold_act_r <= 1'b0;
    end
  end

  // Capture latches the live count
  integer c;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (c = 0; c < 3; c = c + 1)
        cap_r[c] <= {CW{1'b0}};
    end else begin
      for (c = 0; c < 3; c = c + 1)
        if (rise_ev[c])
          cap_r[c] <= cnt_r;
    end
  end

  // ----------------------------------------------------------------
  // APB write side
  // ----------------------------------------------------------------
  integer w;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r   <= 8'h00;
      presc_r  <= `RST_PRESC;
      period_r <= `RST_PERIOD;
      dly_r    <= `RST_DLY;
      lvl_r    <= {NCH{1'b0}};
      mask_r   <= {`ST_W{1'b0}};
      for (w = 0; w < NCH; w = w + 1) begin
        rise_r[w] <= `RST_EDGE;
        fall_r[w] <= `RST_EDGE;
      end
    end else begin
      if (do_load)
        ctrl_r[`CTRL_LOAD] <= 1'b0;
      if (stop)
        ctrl_r[`CTRL_RUN] <= 1'b0;
      if (acc_wr) begin
        case (paddr)
          `OFS_CTRL: begin
            // Software request wins over the hardware clear
            ctrl_r[5:0] <= pwdata[5:0];
          end
          `OFS_PRESC:    presc_r  <= pwdata[CW-1:0];
          `OFS_PERIOD:   period_r <= pwdata[CW-1:0];
          `OFS_SYNC_DLY: dly_r    <= pwdata[CW-1:0];
          `OFS_HOLD_LVL: lvl_r    <= pwdata[NCH-1:0];
          `OFS_INT_MASK: mask_r   <= pwdata[`ST_W-1:0];
          default: begin
            if (edge_hit && paddr[2])
              fall_r[eidx] <= pwdata[CW-1:0];
            else if (edge_hit)
              rise_r[eidx] <= pwdata[CW-1:0];
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // APB read side
  // ----------------------------------------------------------------
  // Data and error are latched in the setup cycle, so no wait states
  reg [31:0] rd_nxt;
  reg        err_nxt;

  always @* begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = 1'b0;
    case (paddr)
      `OFS_CTRL:     rd_nxt[7:0] = {run, hold_act_r, ctrl_r[5:0]};
      `OFS_PRESC:    rd_nxt[CW-1:0] = presc_r;
      `OFS_PERIOD:   rd_nxt[CW-1:0] = period_r;
      `OFS_SYNC_DLY: rd_nxt[CW-1:0] = dly_r;
      `OFS_HOLD_LVL: rd_nxt[NCH-1:0] = lvl_r;
      `OFS_COUNT:    rd_nxt[CW-1:0] = cnt_r;
      `OFS_INT_STAT: rd_nxt[`ST_W-1:0] = stat_r;
      `OFS_INT_MASK: rd_nxt[`ST_W-1:0] = mask_r;
      `OFS_CAP0:     rd_nxt[CW-1:0] = cap_r[0];
      `OFS_CAP1:     rd_nxt[CW-1:0] = cap_r[1];
      `OFS_CAP2:     rd_nxt[CW-1:0] = cap_r[2];
      default: begin
        if (edge_hit && paddr[2])
          rd_nxt[CW-1:0] = fall_r[eidx];
        else if (edge_hit)
          rd_nxt[CW-1:0] = rise_r[eidx];
        else
          err_nxt = 1'b1;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      err_r  <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
      err_r  <= err_nxt;
    end
  end

  // Chain order is fixed by wiring sync_out of n to sync_in of n+1

endmodule // six_channel_pwm

`default_nettype wire
